/* scem_map.vh */
`ifndef SCEM_MAP_VH
`define SCEM_MAP_VH
// =====================================================================
// Register selectors for the query port
`define SCEM_SEL_QCOND   3'h0
`define SCEM_SEL_QEVENT  3'h1
`define SCEM_SEL_QENAB   3'h2
`define SCEM_SEL_OCOND   3'h3
`define SCEM_SEL_OEVENT  3'h4
`define SCEM_SEL_OENAB   3'h5
`define SCEM_SEL_SUMMARY 3'h6
`define SCEM_SEL_ALARMS  3'h7
// =====================================================================
// Questionable bit positions
`define SCEM_Q_OVP       0
`define SCEM_Q_OT        3
`define SCEM_Q_REMOTE    10
`define SCEM_Q_OUTON     11
`define SCEM_Q_PF        13
// =====================================================================
// Operation bit positions and masks
`define SCEM_O_CV        8
`define SCEM_O_CC        9
`define SCEM_O_CP        10
`define SCEM_O_IMPL_MASK 16'h0F00
// =====================================================================
// Summary byte bit positions
`define SCEM_S_SECQ      0
`define SCEM_S_ERR       2
`define SCEM_S_QUES      3
`define SCEM_S_OPER      7
// =====================================================================
// Reset values and codes
`define SCEM_QENAB_RST   16'hFFFF
`define SCEM_SAFETY_CODE 16'hFC19
`endif

/* scem_status.v */
`timescale 1ns/1ps
`default_nettype none
`include "scem_map.vh"

module scem_status #(
   parameter        SAFETY_VARIANT = 1,
   parameter        CNT_W          = 16
) (
   input  wire             i_sys_clk,
   input  wire             i_reset_n,
   input  wire             i_overvoltage_alarm,
   input  wire             i_overtemperature_alarm,
   input  wire             i_power_fail_alarm,
   input  wire             i_safety_overvoltage_alarm,
   input  wire             i_remote_active,
   input  wire             i_output_on,
   input  wire             i_constant_voltage_flag,
   input  wire             i_constant_current_flag,
   input  wire             i_constant_power_flag,
   input  wire             i_live_state_register_extra_op,
   input  wire             i_sec_ques_active,
   input  wire             i_error_queue_nonempty,
   input  wire             i_rd_strobe,
   input  wire [2:0]       i_rd_sel,
   input  wire             i_wr_qenable,
   input  wire             i_wr_oenable,
   input  wire [15:0]      i_wr_data,
   input  wire             i_error_query,
   input  wire             i_clear_status,
   output reg  [15:0]      o_rd_data,
   output reg              o_rd_valid,
   output wire [7:0]       o_summary_byte,
   output reg              o_safety_error_push,
   output wire [15:0]      o_safety_error_code,
   output reg              o_error_queue_flush
);

   // ==================================================================
   // Latched alarms and live state
   reg              safety_latched;
   reg  [3:0]       alarm_hold;
   reg  [CNT_W-1:0] alarm_count;
   reg  [15:0]      live_state_register;
   reg  [15:0]      prev_q;
   reg  [15:0]      prev_o;
   reg  [15:0]      questionable_event;
   reg  [15:0]      questionable_enable;
   reg  [15:0]      operation_event;
   reg  [15:0]      operation_enable;
   reg  [15:0]      operation_condition;
   reg  [3:0]       next_hold;
   reg  [CNT_W-1:0] next_count;
   integer          k;

   wire safety_on = (SAFETY_VARIANT != 0) && (safety_latched || i_safety_overvoltage_alarm);
   wire [3:0] alarm_live = {i_power_fail_alarm, i_overtemperature_alarm,
                            i_overvoltage_alarm, 1'b0};

   assign o_safety_error_code = `SCEM_SAFETY_CODE;

   // Overvoltage, overtemperature and power-fail alarms are held until acknowledged; an acknowledge only drops a bit whose
   // source has gone, so a standing alarm cannot be hidden by a stray query.
   always @* begin
      next_hold  = alarm_hold | alarm_live;
      next_count = alarm_count;
      if (i_error_query) begin
         for (k = 1; k < 4; k = k + 1) begin
            if (alarm_hold[k] && !alarm_live[k]) begin
               next_hold[k] = 1'b0;
               next_count   = next_count + 1'b1;
            end
         end
      end
   end

   always @* begin
      live_state_register = 16'h0000;
      live_state_register[`SCEM_Q_OVP]    = alarm_hold[1] | safety_on;
      live_state_register[`SCEM_Q_OT]     = alarm_hold[2];
      live_state_register[`SCEM_Q_PF]     = alarm_hold[3] | safety_on;
      live_state_register[`SCEM_Q_REMOTE] = i_remote_active;
      live_state_register[`SCEM_Q_OUTON]  = i_output_on;
      operation_condition = 16'h0000;
      operation_condition[`SCEM_O_CV]     = i_constant_voltage_flag;
      operation_condition[`SCEM_O_CC]     = i_constant_current_flag;
      operation_condition[`SCEM_O_CP]     = i_constant_power_flag;
      operation_condition[`SCEM_O_CP+1]   = i_live_state_register_extra_op;
   end

   wire rd_qev = i_rd_strobe && (i_rd_sel == `SCEM_SEL_QEVENT);
   wire rd_oev = i_rd_strobe && (i_rd_sel == `SCEM_SEL_OEVENT);
   wire [15:0] q_chg = live_state_register ^ prev_q;
   wire [15:0] o_chg = (operation_condition ^ prev_o) & operation_enable;

   // ==================================================================
   // Summary byte
   wire ques_sum = |(questionable_event & questionable_enable);
   wire oper_sum = |operation_event;
   assign o_summary_byte = {oper_sum, 3'h0, ques_sum, i_error_queue_nonempty,
                            1'b0, i_sec_ques_active};

   // ==================================================================
   // State registers
   always @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         safety_latched      <= 1'b0;
         alarm_hold          <= 4'h0;
         alarm_count         <= {CNT_W{1'b0}};
         prev_q              <= 16'h0000;
         prev_o              <= 16'h0000;
         questionable_event  <= 16'h0000;
         operation_event     <= 16'h0000;
         questionable_enable <= `SCEM_QENAB_RST;
         operation_enable    <= `SCEM_O_IMPL_MASK;
         o_safety_error_push <= 1'b0;
         o_error_queue_flush <= 1'b0;
      end else begin
         // Only a reset, i.e. a power cycle, ends a safety alarm.
         if (SAFETY_VARIANT != 0 && i_safety_overvoltage_alarm)
            safety_latched <= 1'b1;
         o_safety_error_push <= (SAFETY_VARIANT != 0) && i_safety_overvoltage_alarm
                                && !safety_latched;
         alarm_hold  <= next_hold;
         alarm_count <= next_count;
         prev_q      <= live_state_register;
         prev_o      <= operation_condition;
         o_error_queue_flush <= i_clear_status;
         // New change wins over a read clear in the same cycle.
         if (i_clear_status) begin
            questionable_event <= q_chg;
            operation_event    <= o_chg;
         end else begin
            questionable_event <= (rd_qev ? 16'h0000 : questionable_event) | q_chg;
            operation_event    <= (rd_oev ? 16'h0000 : operation_event) | o_chg;
         end
         if (i_wr_qenable)
            questionable_enable <= i_wr_data;
         if (i_wr_oenable)
            operation_enable <= i_wr_data & `SCEM_O_IMPL_MASK;
      end
   end

   // ==================================================================
   // Read port; values are binary, their decimal form equals the weight sum.
   always @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_rd_data  <= 16'h0000;
         o_rd_valid <= 1'b0;
      end else begin
         o_rd_valid <= i_rd_strobe;
         if (i_rd_strobe) begin
            case (i_rd_sel)
               `SCEM_SEL_QCOND:   o_rd_data <= live_state_register;
               `SCEM_SEL_QEVENT:  o_rd_data <= questionable_event;
               `SCEM_SEL_QENAB:   o_rd_data <= questionable_enable;
               `SCEM_SEL_OCOND:   o_rd_data <= operation_condition;
               `SCEM_SEL_OEVENT:  o_rd_data <= operation_event;
               `SCEM_SEL_OENAB:   o_rd_data <= operation_enable;
               `SCEM_SEL_SUMMARY: o_rd_data <= {8'h00, o_summary_byte};
               `SCEM_SEL_ALARMS:  o_rd_data <= alarm_count[15:0];
               default:           o_rd_data <= 16'h0000;
            endcase
         end
      end
   end

endmodule // scem_status
`default_nettype wire

/* scem_status_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
`include "scem_map.vh"
module scem_mon (
   input wire logic        i_sys_clk,
   input wire logic        i_reset_n,
   input wire logic        i_rd_strobe,
   input wire logic        i_clear_status,
   input wire logic        i_sec_ques_active,
   input wire logic        i_error_queue_nonempty,
   input wire logic        i_safety_overvoltage_alarm,
   input wire logic [15:0] o_rd_data,
   input wire logic        o_rd_valid,
   input wire logic [7:0]  o_summary_byte,
   input wire logic        o_safety_error_push,
   input wire logic [15:0] o_safety_error_code,
   input wire logic        o_error_queue_flush
);
   // ==========
   // Checks
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_reset_n);
   sequence s_read; i_rd_strobe ##1 o_rd_valid; endsequence
   sequence s_cls; i_clear_status ##1 o_error_queue_flush; endsequence
   AST_RD_ANSWER: assert property (i_rd_strobe |-> s_read)
      else $error("read not answered");
   AST_RD_CAUSE: assert property (o_rd_valid |-> $past(i_rd_strobe))
      else $error("valid without read");
   AST_RD_HOLD: assert property (!i_rd_strobe |=> $stable(o_rd_data))
      else $error("read data moved");
   AST_SUM_DIRECT: assert property (o_summary_byte[`SCEM_S_SECQ] == i_sec_ques_active
      && o_summary_byte[`SCEM_S_ERR] == i_error_queue_nonempty)
      else $error("direct summary bits wrong");
   AST_SUM_UNUSED: assert property (o_summary_byte[6:4] == 3'h0 && !o_summary_byte[1])
      else $error("unused summary bit set");
   AST_FLUSH: assert property (i_clear_status |-> s_cls)
      else $error("no flush after clear");
   AST_FLUSH_CAUSE: assert property ($rose(o_error_queue_flush) |-> $past(i_clear_status))
      else $error("flush without clear");
   AST_SAFE_PUSH: assert property ($rose(i_safety_overvoltage_alarm) |-> ##[0:1] o_safety_error_push)
      else $error("safety code not queued");
   AST_SAFE_CODE: assert property (o_safety_error_push |-> o_safety_error_code == `SCEM_SAFETY_CODE)
      else $error("safety code wrong");
   AST_PUSH_ONE: assert property (o_safety_error_push |=> !o_safety_error_push)
      else $error("safety push too long");
endmodule // scem_mon
bind scem_status scem_mon u_mon (.i_sys_clk, .i_reset_n, .i_rd_strobe, .i_clear_status,
   .i_sec_ques_active, .i_error_queue_nonempty, .i_safety_overvoltage_alarm, .o_rd_data,
   .o_rd_valid, .o_summary_byte, .o_safety_error_push, .o_safety_error_code,
   .o_error_queue_flush);
`default_nettype wire

/* scem_host.sv */
`timescale 1ns/1ps
`default_nettype none
`include "scem_map.vh"
module scem_host (
   input wire logic        i_clk,
   input wire logic [15:0] i_data,
   input wire logic        i_valid,
   output var logic        o_rd = 1'b0,
   output var logic [2:0]  o_sel = 3'h0,
   output var logic        o_query = 1'b0
);
   // ==========
   // Host queries
   task automatic rd(input logic [2:0] s, output logic [15:0] d);
      @(posedge i_clk);
      o_rd <= 1'b1;
      o_sel <= s;
      @(posedge i_clk);
      o_rd <= 1'b0;
      repeat (4) begin
         @(posedge i_clk);
         if (i_valid === 1'b1) break;
      end
      d = (i_valid === 1'b1) ? i_data : 16'hXXXX;
   endtask
   // The live state is read first, since the acknowledge may wipe alarm bits.
   task automatic ack(output logic [15:0] q);
      rd(`SCEM_SEL_QCOND, q);
      o_query <= 1'b1;
      @(posedge i_clk);
      o_query <= 1'b0;
   endtask
endmodule // scem_host
`default_nettype wire

/* testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "scem_map.vh"
module testbench;
   logic        i_sys_clk = 1'b0;
   logic        i_reset_n = 1'b0;
   logic [11:0] in_v = 12'h000;
   logic        wq = 1'b0, wo = 1'b0, cls = 1'b0;
   logic [15:0] wd = 16'h0000, v;
   wire logic   rd, eq, vld;
   wire logic [2:0]  sel;
   wire logic [15:0] rdat;
   wire logic [7:0]  sb;
   int          bad_count = 0, compares = 0, cyc = 0;
   scem_status uut (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
      .i_overvoltage_alarm(in_v[0]), .i_overtemperature_alarm(in_v[1]),
      .i_power_fail_alarm(in_v[2]), .i_safety_overvoltage_alarm(in_v[3]),
      .i_remote_active(in_v[4]), .i_output_on(in_v[5]), .i_constant_voltage_flag(in_v[6]),
      .i_constant_current_flag(in_v[7]), .i_constant_power_flag(in_v[8]),
      .i_live_state_register_extra_op(in_v[9]), .i_sec_ques_active(in_v[10]),
      .i_error_queue_nonempty(in_v[11]), .i_rd_strobe(rd), .i_rd_sel(sel),
      .i_wr_qenable(wq), .i_wr_oenable(wo), .i_wr_data(wd), .i_error_query(eq),
      .i_clear_status(cls), .o_rd_data(rdat), .o_rd_valid(vld), .o_summary_byte(sb),
      .o_safety_error_push(), .o_safety_error_code(), .o_error_queue_flush());
   scem_host host (.i_clk(i_sys_clk), .i_data(rdat), .i_valid(vld), .o_rd(rd),
      .o_sel(sel), .o_query(eq));
   // ==========
   // Helpers
   initial forever #25 i_sys_clk = ~i_sys_clk;
   always @(posedge i_sys_clk) if (++cyc > 3000) begin
      bad_count++;
      tally_and_finish();
   end
   task automatic tally_and_finish;
      if (bad_count == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string n, input logic [15:0] s, e);
      compares++;
      if (s !== e) begin
         bad_count++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic q, input logic [15:0] d);
      @(posedge i_sys_clk) {wq, wo, wd} <= {q, !q, d};
      @(posedge i_sys_clk) {wq, wo} <= 2'b00;
   endtask
   // Three idle edges let a condition change reach its event bit.
   task automatic sv(input int b, input logic x);
      @(posedge i_sys_clk) in_v[b] <= x;
      repeat (3) @(posedge i_sys_clk);
   endtask
   // ==========
   // Scenarios
   task automatic t_reset_enab;
      host.rd(`SCEM_SEL_QENAB, v); chk("qenab", v, `SCEM_QENAB_RST);
      host.rd(`SCEM_SEL_OENAB, v); chk("oenab", v, `SCEM_O_IMPL_MASK);
      chk("stb", sb, 16'h0000);
      wr(0, 16'hFFFF); host.rd(`SCEM_SEL_OENAB, v); chk("oenab", v, 16'h0F00);
      wr(0, 16'h0700); host.rd(`SCEM_SEL_OENAB, v); chk("oenab", v, 16'h0700);
      wr(1, 16'h0C09); host.rd(`SCEM_SEL_QENAB, v); chk("qenab", v, 16'h0C09);
   endtask
   task automatic t_groups;
      sv(4, 1); sv(5, 1); sv(1, 1);
      chk("stb3", sb[3], 16'h0001);
      host.rd(`SCEM_SEL_QCOND, v); chk("qcond", v, 16'h0C08);
      host.rd(`SCEM_SEL_QEVENT, v); chk("qevent", v, 16'h0C08);
      chk("stb3", sb[3], 16'h0000);
      sv(6, 1); host.rd(`SCEM_SEL_OEVENT, v); chk("oevent", v, 16'h0100);
      sv(9, 1); chk("stb7", sb[7], 16'h0000);
      host.rd(`SCEM_SEL_OCOND, v); chk("ocond", v, 16'h0900);
   endtask
   task automatic t_alarms;
      sv(0, 1); sv(0, 0);
      host.ack(v); chk("qcond", v, 16'h0C09);
      host.rd(`SCEM_SEL_QCOND, v); chk("qcond", v, 16'h0C08);
      host.rd(`SCEM_SEL_ALARMS, v); chk("alarms", v, 16'h0001);
      sv(3, 1); host.ack(v); chk("safety_overvoltage_alarm", v & 16'h2001, 16'h2001);
      sv(3, 0); host.rd(`SCEM_SEL_QCOND, v); chk("safety_overvoltage_alarm", v & 16'h2001, 16'h2001);
      sv(7, 1); sv(10, 1); sv(11, 1); chk("stb", sb & 8'h8D, 16'h008D);
      @(posedge i_sys_clk) cls <= 1'b1;
      @(posedge i_sys_clk) cls <= 1'b0;
      @(posedge i_sys_clk) chk("stb", sb & 8'h88, 16'h0000);
   endtask
   initial begin
      repeat (4) @(posedge i_sys_clk);
      i_reset_n <= 1'b1;
      t_reset_enab();
      t_groups();
      t_alarms();
      tally_and_finish();
   end
endmodule // testbench
`default_nettype wire
